// File: shared/vbw_map.svh
// register map, field positions and timing counts of the video memory host
// assumes a 10 MHz system clock and 32-bit register data
`ifndef VBW_MAP_SVH
`define VBW_MAP_SVH

`define VB_REG_CMD      8'h00
`define VB_REG_ADDR     8'h04
`define VB_REG_MASK     8'h08
`define VB_REG_STAT     8'h0c

`define VB_CMD_OP       2:0
`define VB_CMD_MASKED   3
`define VB_ADDR_ROW     8:0
`define VB_ADDR_COL     24:16
`define VB_MASK_IO      7:0
`define VB_MASK_COL     11:8
`define VB_ST_BUSY      0
`define VB_ST_START     1
`define VB_ST_SIOOUT    2
`define VB_ST_ERR       3
`define VB_ST_HALF      4
`define VB_ST_IO        15:8

`define VB_ROW_MSB      8
`define VB_COL_ALIGN    2'h0
`define VB_CLK_MHZ      10
`define VB_TSTS_NS      30
`define VB_TSTS_CYC     ((`VB_TSTS_NS * `VB_CLK_MHZ + 999) / 1000)

`endif

// File: shared/vbw_pkg.sv
// types shared by the video memory host: commands, sequencer states, pins
// assumes the register map header for all numeric positions
package vbw_pkg;

	typedef enum logic [2:0] {
		VB_OP_FLASH, VB_OP_BLOCK, VB_OP_RDX, VB_OP_SPLRD,
		VB_OP_WRX, VB_OP_SPLWR, VB_OP_SERIAL, VB_OP_NONE
	} vbw_op_type;

	typedef enum logic [3:0] {
		ST_IDLE, ST_SETUP, ST_RASL, ST_COL, ST_CASL, ST_DTR, ST_PRE, ST_SCH, ST_SCL
	} vbw_st_type;

	// pins toward the memory; io and serial data are driven when the _oe_n is low
	typedef struct packed {
		logic       ras_n;
		logic       cas_n;
		logic       we_n;
		logic       transfer_outen_n_n;
		logic       dsf;
		logic       sc;
		logic       io_oe_n;
		logic       sio_oe_n;
		logic [8:0] addr;
		logic [7:0] io_o;
	} vbw_pins_type;

	localparam vbw_pins_type VBW_PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
		transfer_outen_n_n: 1'b1, dsf: 1'b0, sc: 1'b0, io_oe_n: 1'b1, sio_oe_n: 1'b1,
		addr: 9'h000, io_o: 8'h00};

endpackage : vbw_pkg

// File: verilog/vbw_host.sv
// host sequencer for a dual-port video memory: flash/block writes and transfers
// assumes an APB master on the register side and the memory on VRAM pins
//
// Contract
// - flash write row taken at RAS fall; host drives the I/O mask there
// - column enables on I/O at CAS fall, independent of the I/O mask
// - full transfer must set start address before split or serial access
// - read transfer: we_n high, dsf low; host raises transfer_outen_n
// - transfer_outen_n rise lies between old and new data serial clocks
// - host releases serial pins before first access after read transfer
// - no serial clock while RAS low in a write transfer
// - write-back row msb must match the row msb of the loading transfer
// - split read: we_n high, dsf high; spacing after serial clock kept
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "vbw_map.svh"

module vbw_host (
	input  wire logic                 CLOCK,
	input  wire logic                 ARST_N,
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [7:0]           PADDR,
	input  wire logic [31:0]          PWDATA,
	output logic      [31:0]          PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	input  wire logic [7:0]           IO_IN,
	input  wire logic                 HALF_IND,
	output vbw_pkg::vbw_pins_type     VRAM
);
	import vbw_pkg::*;

	typedef struct packed {
		vbw_st_type   st;
		vbw_op_type   op;
		logic         masked;
		logic [8:0]   row;
		logic [8:0]   col;
		logic [7:0]   mask;
		logic [3:0]   cmask;
		logic [8:0]   cnt;
		logic [3:0]   gap;
		logic         start_ok;
		logic         sio_out;
		logic         loaded;
		logic         load_msb;
		logic         err;
		logic [31:0]  prdata;
		logic         pready;
		logic         pslverr;
		vbw_pins_type pins;
	} vbw_state_type;

	vbw_state_type s_r;
	vbw_state_type s_nxt;
	logic          acc;
	logic          hit;
	logic          refuse;
	logic          xfer;
	vbw_op_type    new_op;
	logic [31:0]   rd;

	// next state: bus slave, command launch, sequencer and pin levels
	always_comb begin
		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		acc = PSEL & PENABLE & s_r.pready;
		hit = (PADDR == `VB_REG_CMD) || (PADDR == `VB_REG_ADDR) ||
			(PADDR == `VB_REG_MASK) || (PADDR == `VB_REG_STAT);
		new_op = vbw_op_type'(PWDATA[`VB_CMD_OP]);
		rd = 32'h0000_0000;
		unique case (PADDR)
			`VB_REG_CMD:  rd[3:0] = {s_r.masked, s_r.op};
			`VB_REG_ADDR: rd = {7'h00, s_r.col, 7'h00, s_r.row};
			`VB_REG_MASK: rd[11:0] = {s_r.cmask, s_r.mask};
			`VB_REG_STAT: rd[15:0] = {IO_IN, 3'h0, HALF_IND, s_r.err, s_r.sio_out,
				s_r.start_ok, s_r.st != ST_IDLE};
			default:      rd = 32'h0000_0000;
		endcase
		// registered answer: ready in the first access cycle, so no wait states
		if (PSEL && !PENABLE) begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = !hit;
			s_nxt.prdata = PWRITE ? 32'h0000_0000 : rd;
		end
		refuse = (s_r.st != ST_IDLE) || (new_op == VB_OP_NONE) ||
			((new_op == VB_OP_SPLRD || new_op == VB_OP_SPLWR ||
			new_op == VB_OP_SERIAL) && !s_r.start_ok) ||
			(new_op == VB_OP_SPLWR && (s_r.sio_out ||
			(s_r.loaded && s_r.row[`VB_ROW_MSB] != s_r.load_msb)));
		if (s_r.gap != 4'h0)
			s_nxt.gap = s_r.gap - 4'h1;
		if (acc && PWRITE && hit) begin
			unique case (PADDR)
				`VB_REG_CMD: begin
					if (refuse) begin
						s_nxt.err = 1'b1;
					end else begin
						s_nxt.st = ST_SETUP;
						s_nxt.op = new_op;
						s_nxt.masked = PWDATA[`VB_CMD_MASKED];
					end
				end
				`VB_REG_ADDR: begin
					s_nxt.row = PWDATA[`VB_ADDR_ROW];
					s_nxt.col = PWDATA[`VB_ADDR_COL];
				end
				`VB_REG_MASK: begin
					s_nxt.mask = PWDATA[`VB_MASK_IO];
					s_nxt.cmask = PWDATA[`VB_MASK_COL];
				end
				default: s_nxt.err = s_r.err & ~PWDATA[`VB_ST_ERR];
			endcase
		end
		// sequencer; serial clocks only start from idle, so never under RAS low
		// serial clocks idle-only
		unique case (s_r.st)
			ST_IDLE: ;
			ST_SETUP: begin
				// split transfers wait out the spacing after the last serial clock
				if (s_r.op == VB_OP_SERIAL)
					s_nxt.st = ST_SCH;
				else if (!((s_r.op == VB_OP_SPLRD || s_r.op == VB_OP_SPLWR) && s_r.gap != 4'h0))
					s_nxt.st = ST_RASL;
			end
			ST_RASL: s_nxt.st = (s_r.op == VB_OP_FLASH) ? ST_PRE : ST_COL;
			ST_COL:  s_nxt.st = ST_CASL;
			ST_CASL: s_nxt.st = (s_r.op == VB_OP_BLOCK) ? ST_PRE : ST_DTR;
			ST_DTR: begin
				s_nxt.st = ST_PRE;
				// direction and start address follow full transfers
				if (s_r.op == VB_OP_RDX) begin
					s_nxt.start_ok = 1'b1;
					s_nxt.sio_out = 1'b1;
				end
				if (s_r.op == VB_OP_WRX) begin
					s_nxt.start_ok = 1'b1;
					s_nxt.sio_out = 1'b0;
				end
				// remember the row msb of loaded data
				if (s_r.op == VB_OP_RDX || s_r.op == VB_OP_SPLRD) begin
					s_nxt.loaded = 1'b1;
					s_nxt.load_msb = s_r.row[`VB_ROW_MSB];
				end
			end
			ST_PRE: s_nxt.st = ST_IDLE;
			ST_SCH: s_nxt.st = ST_SCL;
			ST_SCL: begin
				s_nxt.gap = 4'(`VB_TSTS_CYC);
				s_nxt.st = (s_r.col <= 9'h001) ? ST_IDLE : ST_SCH;
				s_nxt.col = s_r.col - 9'h001;
			end
			// unused state codes fall back to idle rather than lock up
			default: s_nxt.st = ST_IDLE;
		endcase
		// pin levels for the state being entered
		xfer = s_nxt.op inside {VB_OP_RDX, VB_OP_SPLRD, VB_OP_WRX, VB_OP_SPLWR};
		s_nxt.pins = VBW_PINS_IDLE;
		s_nxt.pins.addr = s_r.pins.addr;
		// serial pins released unless the memory expects input
		s_nxt.pins.sio_oe_n = !(s_nxt.start_ok && !s_nxt.sio_out);
		if (s_nxt.st inside {ST_SETUP, ST_RASL}) begin
			s_nxt.pins.addr = s_nxt.row;
			s_nxt.pins.ras_n = (s_nxt.st != ST_RASL);
			// decode levels at the RAS fall
			s_nxt.pins.transfer_outen_n_n = !xfer;
			s_nxt.pins.dsf = s_nxt.op inside {VB_OP_FLASH, VB_OP_SPLRD, VB_OP_SPLWR};
			// we_n low selects mask write for flash fills, masked block fills and write transfers
			s_nxt.pins.we_n = !(s_nxt.op inside {VB_OP_FLASH, VB_OP_WRX, VB_OP_SPLWR} ||
				(s_nxt.op == VB_OP_BLOCK && s_nxt.masked));
			// mask on I/O at the RAS fall whenever it is a mask write
			s_nxt.pins.io_oe_n = s_nxt.pins.we_n;
			s_nxt.pins.io_o = s_nxt.mask;
		end
		if (s_nxt.st inside {ST_COL, ST_CASL, ST_DTR}) begin
			s_nxt.pins.ras_n = 1'b0;
			s_nxt.pins.cas_n = (s_nxt.st == ST_COL);
			s_nxt.pins.transfer_outen_n_n = 1'b1;
			if (s_nxt.st != ST_DTR)
				s_nxt.pins.transfer_outen_n_n = !xfer;
			s_nxt.pins.we_n = s_r.pins.we_n;
			if (s_nxt.op == VB_OP_BLOCK) begin
				// aligned column, dsf and column enables at CAS fall
				s_nxt.pins.addr = {s_nxt.col[8:2], `VB_COL_ALIGN};
				s_nxt.pins.dsf = 1'b1;
				s_nxt.pins.we_n = 1'b0;
				s_nxt.pins.io_oe_n = 1'b0;
				s_nxt.pins.io_o = {4'h0, s_nxt.cmask};
			end else begin
				// split start uses the low column bits only
				s_nxt.pins.addr = s_nxt.op inside {VB_OP_SPLRD, VB_OP_SPLWR} ?
					{1'b0, s_nxt.col[7:0]} : s_nxt.col;
			end
		end
		s_nxt.pins.sc = (s_nxt.st == ST_SCH);
	end

	// state register
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			s_r <= '0;
			s_r.pins <= VBW_PINS_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign PRDATA = s_r.prdata;
	assign PREADY = s_r.pready;
	assign PSLVERR = s_r.pslverr;
	assign VRAM = s_r.pins;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);

	chk_flash_decode: assert property ($fell(VRAM.ras_n) && s_r.op == VB_OP_FLASH |->
		VRAM.cas_n && VRAM.transfer_outen_n_n && !VRAM.we_n && VRAM.dsf)
		else $error("flash write decode levels wrong at RAS fall");
	chk_block_phases: assert property ($fell(VRAM.ras_n) && s_r.op == VB_OP_BLOCK |->
		!VRAM.dsf && VRAM.transfer_outen_n_n ##2 $fell(VRAM.cas_n) && VRAM.dsf && !VRAM.we_n)
		else $error("block write strobe sequence wrong");
	chk_mask_drive: assert property ($fell(VRAM.ras_n) && !VRAM.we_n |->
		!VRAM.io_oe_n && VRAM.io_o == s_r.mask)
		else $error("I/O mask not driven at RAS fall");
	chk_col_enable: assert property ($fell(VRAM.cas_n) && s_r.op == VB_OP_BLOCK |->
		VRAM.io_o[3:0] == s_r.cmask && VRAM.addr[1:0] == 2'h0)
		else $error("block column enables or alignment wrong");
	chk_read_xfer: assert property ($fell(VRAM.ras_n) && s_r.op == VB_OP_RDX |->
		!VRAM.transfer_outen_n_n && VRAM.we_n && !VRAM.dsf ##3 $rose(VRAM.transfer_outen_n_n) && !VRAM.ras_n)
		else $error("read transfer missing transfer_outen_n rise");
	// serial clock never with RAS low
	chk_sc_ras: assert property (!VRAM.ras_n |-> !VRAM.sc)
		else $error("serial clock high while RAS low");
	// split only after a full transfer
	chk_start_first: assert property ($fell(VRAM.ras_n) &&
		s_r.op inside {VB_OP_SPLRD, VB_OP_SPLWR} |-> s_r.start_ok)
		else $error("split transfer before start address set");
	chk_msb_match: assert property ($fell(VRAM.ras_n) && s_r.op == VB_OP_SPLWR &&
		s_r.loaded |-> VRAM.addr[`VB_ROW_MSB] == s_r.load_msb)
		else $error("split write row msb differs from loaded row");
	// serial pins released after read transfer
	chk_sio_release: assert property ($rose(VRAM.ras_n) && s_r.sio_out |-> VRAM.sio_oe_n)
		else $error("serial pins driven after read transfer");
	// spacing after the last serial clock
	chk_split_gap: assert property ($fell(VRAM.ras_n) &&
		s_r.op inside {VB_OP_SPLRD, VB_OP_SPLWR} |-> s_r.gap == 4'h0 && !$past(VRAM.sc))
		else $error("split transfer too close to serial clock");

	cov_flash: cover property ($fell(VRAM.ras_n) && s_r.op == VB_OP_FLASH);
	cov_block: cover property ($fell(VRAM.cas_n) && s_r.op == VB_OP_BLOCK);
	cov_rdx: cover property ($rose(VRAM.transfer_outen_n_n) && s_r.op == VB_OP_RDX);
	cov_split: cover property ($fell(VRAM.ras_n) && s_r.op == VB_OP_SPLRD);

endmodule : vbw_host

// File: sim/vbw_vram_model.sv
// video memory partner: decodes strobe cycles, keeps serial pointer and half flag
// assumes host pins as in vbw_pkg; no array or serial data is stored
`timescale 1ns/1ps
module vbw_vram_model (
	input  wire vbw_pkg::vbw_pins_type pins,
	output logic [7:0]                 io,
	output logic                       half_ind,
	output vbw_pkg::vbw_op_type        last_op,
	output logic [7:0]                 io_mask,
	output logic [3:0]                 cmask,
	output logic [8:0]                 col
);
	import vbw_pkg::*;
	logic [7:0] io_last  = 8'h00;
	logic [8:0] ptr      = 9'h000;
	logic [8:0] split    = 9'h000;
	logic       split_ok = 1'b0;
	logic       blk      = 1'b0;
	initial last_op = VB_OP_NONE;
	// a released bus shows the inverse of the last driven value
	assign io = pins.io_oe_n ? ~io_last : pins.io_o;
	always @(pins) if (!pins.io_oe_n) io_last = pins.io_o;
	// no load-mask cycle is ever issued, so masks always come from the pins
	always @(negedge pins.ras_n) begin
		blk = 1'b0;
		io_mask = pins.we_n ? 8'hff : (pins.io_oe_n ? ~io_last : pins.io_o);
		if (pins.cas_n && !pins.transfer_outen_n_n)
			last_op = vbw_op_type'(pins.we_n ? 3'h2 + pins.dsf : 3'h4 + pins.dsf);
		else if (pins.cas_n && pins.dsf && !pins.we_n)
			last_op = VB_OP_FLASH;
		else if (pins.cas_n && !pins.dsf)
			blk = 1'b1;
	end
	// early block write; column taken at column strobe fall
	// fill colour is not stored: only cleared columns and masks are kept
	always @(negedge pins.cas_n) begin
		col = blk ? {pins.addr[8:2], 2'h0} : pins.addr;
		cmask = pins.io_oe_n ? ~io_last[3:0] : pins.io_o[3:0];
		if (blk && pins.dsf && !pins.we_n) last_op = VB_OP_BLOCK;
	end
	// full transfer sets start, split read loads the idle half
	always @(posedge pins.transfer_outen_n_n) begin
		if (last_op == VB_OP_RDX || last_op == VB_OP_WRX) begin
			ptr = col;
			split_ok = 1'b0;
		end else if (last_op == VB_OP_SPLRD) begin
			split = {~ptr[8], col[7:0]};
			split_ok = 1'b1;
		end
	end
	// pointer jumps at half end when a split start is pending
	always @(posedge pins.sc) begin
		if (ptr[7:0] == 8'hff && split_ok) begin
			ptr = split;
			split_ok = 1'b0;
		end else
			ptr = ptr + 9'h001;
	end
	assign half_ind = ptr[8];
endmodule : vbw_vram_model

// File: sim/tb_vram_block_write_and_transfer.sv
// bench for the video memory host: APB commands against the memory partner
// assumes an APB slave that answers with pready, and the register map header
`timescale 1ns/1ps
`include "vbw_map.svh"
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, x); end end
module tb_vram_block_write_and_transfer;
	import vbw_pkg::*;
	logic         CLOCK = 1'b0, ARST_N = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]   paddr = 8'h00, io, io_mask;
	logic [31:0]  pwdata = 32'h0, prdata, q;
	logic         pready, pslverr, e, half, m;
	logic [3:0]   cmask;
	logic [8:0]   col, row, c;
	logic [11:0]  k;
	vbw_pins_type pins;
	vbw_op_type   last_op;
	int           errors = 0, n_compared = 0, cyc = 0, s;
	always #50 CLOCK = ~CLOCK;
	vbw_host vbw_host_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .IO_IN(io), .HALF_IND(half), .VRAM(pins));
	vbw_vram_model vbw_vram_model_i (.pins(pins), .io(io), .half_ind(half),
		.last_op(last_op), .io_mask(io_mask), .cmask(cmask), .col(col));
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	// request stands until pready is seen high at a rising edge; data taken there
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge CLOCK);
		penable <= 1'b1;
		do @(posedge CLOCK); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic run(input logic [2:0] op, input logic mk, input logic [8:0] r,
		input logic [8:0] cl, input logic [11:0] mask);
		apb(1'b1, `VB_REG_ADDR, {7'h00, cl, 7'h00, r});
		apb(1'b1, `VB_REG_MASK, {20'h0, mask});
		apb(1'b1, `VB_REG_CMD, {28'h0, mk, op});
		q = 32'h1;
		while (q[`VB_ST_BUSY] !== 1'b0) apb(1'b0, `VB_REG_STAT, 32'h0);
	endtask : run
	// a hung handshake ends the run as a mismatch
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'hb9a6));
		repeat (5) @(posedge CLOCK);
		ARST_N <= 1'b1;
		apb(1'b0, `VB_REG_STAT, 32'h0);
		`CHK(q[3:0], 4'h0)
		apb(1'b0, 8'h10, 32'h0);
		`CHK(e, 1'b1)
		run(3'h3, 1'b0, 9'h000, 9'h000, 12'h000);
		`CHK(q[`VB_ST_ERR], 1'b1)
		`CHK(last_op, VB_OP_NONE)
		apb(1'b1, `VB_REG_STAT, 32'h8);
		$display("test reset and refusal done");
		// every write and transfer kind with random fields, one row half
		row = 9'($urandom);
		for (int op = 0; op < 6; op++) begin
			{m, k, c} = 22'($urandom);
			row[7:0] = 8'($urandom);
			run(3'(op), m, row, c, k);
			`CHK(last_op, vbw_op_type'(op))
			`CHK(q[`VB_ST_SIOOUT], 1'(op == 2 || op == 3))
			`CHK(q[`VB_ST_ERR], 1'b0)
			// a released I/O bus shows the inverse of what the host drove last
			if (op != 2 && op != 3)
				`CHK(q[`VB_ST_IO], ~(op == 1 ? 8'(k[11:8]) : k[7:0]))
			if (op == 1) begin
				`CHK(io_mask, m ? k[7:0] : 8'hff)
				`CHK(col, {c[8:2], 2'h0})
				`CHK(cmask, k[11:8])
			end else begin
				`CHK(io_mask, (op == 2 || op == 3) ? 8'hff : k[7:0])
			end
		end
		$display("test write and transfer kinds done");
		// serial pointer crosses a half, then jumps to the split start
		s = $urandom_range(255);
		run(3'h2, 1'b0, row, 9'(s), 12'h000);
		run(3'h6, 1'b0, row, 9'(256 - s), 12'h000);
		`CHK(q[`VB_ST_HALF], 1'b1)
		run(3'h3, 1'b0, row, 9'($urandom_range(255)), 12'h000);
		run(3'h6, 1'b0, row, 9'h100, 12'h000);
		`CHK(q[`VB_ST_HALF], 1'b0)
		run(3'h5, 1'b0, row, 9'h000, 12'h0ff);
		`CHK(q[`VB_ST_ERR], 1'b1)
		`CHK(last_op, VB_OP_SPLRD)
		$display("test serial halves done");
		final_report();
	end
endmodule : tb_vram_block_write_and_transfer
